//--- logic/cieg_flag.sv
// cieg_flag: cpu-side sticky request flags, set by events, cleared by cpu
// assumes: set and clear pulses in the cpu clock domain
`timescale 1ns/1ps
`default_nettype none
module cieg_flag #(
    parameter int N = 12
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [N-1:0] set_in,
    input  wire logic [N-1:0] clr_in,
    output var  logic [N-1:0] flag_out
);
    // ------------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------------
    // set ignores every enable; set beats clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_out <= '0;
        end else begin
            flag_out <= (flag_out & ~clr_in) | set_in;
        end
    end
endmodule : cieg_flag
`default_nettype wire

//--- logic/cieg_gate.sv
// cieg_gate: interrupt enable gating in front of the cpu vectoring logic
// assumes: apb master in the cpu clock domain; sources are same-clock logic
//
// Overview of operation
// - global gate low blocks every request
// - gate high: each source by own enable
// - reg a: sleep bit 5, cipher bit 4
// - reg a bit 3 gates serial1 and audio
// - reg a: serial0 2, converter 1, radio 0
// - reg a bit 6 spare, no gating effect
// - reg b: port0 5, timer4 4, timer3 3
// - reg b: timer2 2, timer1 1, dma 0
// - reg b bit 7 spare rw, bit 6 ro
// - audio events need shared enable bit 0 too
// - bus controller masks must permit too
// - flags set regardless of reg a and reg b enables
// - clearing module flag re-raises if others remain
`timescale 1ns/1ps
`default_nettype none
module cieg_gate #(
    parameter int BUS_SRC = 2
) (
    input  wire logic                   clk_in,
    input  wire logic                   sys_rst_in,
    // apb slave
    input  wire cieg_pkg::cieg_apb_req_t apb_req_in,
    output var  cieg_pkg::cieg_apb_rsp_t apb_rsp_out,
    // event pulses from peripherals, one per source
    input  wire logic [11:0]            src_event_in,
    // audio receive event, merged with serial1 request
    input  wire logic                   audio_rx_event_in,
    // bus controller module flags and their own masks
    input  wire logic [BUS_SRC-1:0]     bus_mod_flag_in,
    input  wire logic [BUS_SRC-1:0]     bus_mod_mask_in,
    // cpu clears a flag when it vectors or software clears it
    input  wire logic [11:0]            cpu_flag_clr_in,
    // gated requests to the vectoring logic
    output var  logic [11:0]            irq_pending_out,
    output var  logic                   irq_any_out
);
    // ------------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------------
    logic [7:0]  ien_a_reg;
    logic [7:0]  ien_b_reg;
    logic [7:0]  shared_en_reg;
    logic [11:0] flag;
    logic [11:0] flag_set;
    logic [11:0] src_en;
    logic [11:0] pend_next;
    logic        bus_set;
    logic        wr_stb;
    logic        rd_stb;
    logic        addr_ok;
    logic [31:0] rdata;
    cieg_pkg::cieg_apb_state_t state_reg;

    // apb access phase is taken in the second cycle, zero wait states
    assign wr_stb = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite
                  & (state_reg == cieg_pkg::CIEG_ACCESS);
    assign rd_stb = apb_req_in.psel & apb_req_in.penable & ~apb_req_in.pwrite
                  & (state_reg == cieg_pkg::CIEG_ACCESS);

    // address decode, shared by read and write paths
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == cieg_pkg::IEN_A_OFFSET)
                  | (a == cieg_pkg::IEN_B_OFFSET)
                  | (a == cieg_pkg::FLAG_OFFSET)
                  | (a == cieg_pkg::PEND_OFFSET)
                  | (a == cieg_pkg::SHARED_OFFSET);
    endfunction : is_mapped

    assign addr_ok = is_mapped(apb_req_in.paddr);

    // setup then access; pready answers in the access cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg <= cieg_pkg::CIEG_IDLE;
        end else begin
            unique case (state_reg)
                cieg_pkg::CIEG_IDLE: begin
                    if (apb_req_in.psel && !apb_req_in.penable) begin
                        state_reg <= cieg_pkg::CIEG_ACCESS;
                    end
                end
                cieg_pkg::CIEG_ACCESS: begin
                    state_reg <= cieg_pkg::CIEG_IDLE;
                end
            endcase
        end
    end

    // register a: every bit read/write, bit 6 stored but unused
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ien_a_reg <= cieg_pkg::IEN_A_RESET;
        end else if (wr_stb &&
                     apb_req_in.paddr == cieg_pkg::IEN_A_OFFSET) begin
            ien_a_reg <= apb_req_in.pwdata[7:0];
        end
    end

    // register b: bit 6 is read-only and never stored
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ien_b_reg <= cieg_pkg::IEN_B_RESET;
        end else if (wr_stb &&
                     apb_req_in.paddr == cieg_pkg::IEN_B_OFFSET) begin
            ien_b_reg <= {apb_req_in.pwdata[7], 1'b0,
                          apb_req_in.pwdata[5:0]};
        end
    end

    // audio module's own enable; applied directly, no extra mask stage
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            shared_en_reg <= cieg_pkg::SHARED_RESET;
        end else if (wr_stb &&
                     apb_req_in.paddr == cieg_pkg::SHARED_OFFSET) begin
            shared_en_reg <= apb_req_in.pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // source flags
    // ------------------------------------------------------------------
    // bus controller flags share the port0 line through their own masks
    cieg_shared_src #(
        .N (BUS_SRC)
    ) u_bus_src (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .mod_flag_in (bus_mod_flag_in),
        .mod_mask_in (bus_mod_mask_in),
        .cpu_set_out (bus_set)
    );

    // fold shared sources onto their vectors
    always_comb begin
        flag_set = src_event_in;
        flag_set[cieg_pkg::SRC_SER1] = src_event_in[cieg_pkg::SRC_SER1]
            | (audio_rx_event_in & shared_en_reg[0]);
        flag_set[cieg_pkg::SRC_PORT0] = src_event_in[cieg_pkg::SRC_PORT0]
            | bus_set;
    end

    cieg_flag #(
        .N (cieg_pkg::NUM_SRC)
    ) u_flag (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (flag_set),
        .clr_in     (cpu_flag_clr_in),
        .flag_out   (flag)
    );

    // ------------------------------------------------------------------
    // gating
    // ------------------------------------------------------------------
    // map register bits onto the source index order
    always_comb begin
        src_en = '0;
        src_en[cieg_pkg::SRC_RADIO]  = ien_a_reg[cieg_pkg::A_RADIO_BIT];
        src_en[cieg_pkg::SRC_CONV]   = ien_a_reg[cieg_pkg::A_CONV_BIT];
        src_en[cieg_pkg::SRC_SER0]   = ien_a_reg[cieg_pkg::A_SER0_BIT];
        src_en[cieg_pkg::SRC_SER1]   = ien_a_reg[cieg_pkg::A_SER1_BIT];
        src_en[cieg_pkg::SRC_CIPHER] = ien_a_reg[cieg_pkg::A_CIPHER_BIT];
        src_en[cieg_pkg::SRC_SLEEP]  = ien_a_reg[cieg_pkg::A_SLEEP_BIT];
        src_en[cieg_pkg::SRC_DMA]    = ien_b_reg[cieg_pkg::B_DMA_BIT];
        src_en[cieg_pkg::SRC_TIMER1] = ien_b_reg[cieg_pkg::B_TIMER1_BIT];
        src_en[cieg_pkg::SRC_TIMER2] = ien_b_reg[cieg_pkg::B_TIMER2_BIT];
        src_en[cieg_pkg::SRC_TIMER3] = ien_b_reg[cieg_pkg::B_TIMER3_BIT];
        src_en[cieg_pkg::SRC_TIMER4] = ien_b_reg[cieg_pkg::B_TIMER4_BIT];
        src_en[cieg_pkg::SRC_PORT0]  = ien_b_reg[cieg_pkg::B_PORT0_BIT];
    end

    // gate low masks all; gate high defers to each enable
    assign pend_next = ien_a_reg[cieg_pkg::A_GATE_BIT]
                     ? (flag & src_en)
                     : 12'h000;

    // registered outputs to the vectoring logic
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_pending_out <= 12'h000;
            irq_any_out     <= 1'b0;
        end else begin
            irq_pending_out <= pend_next;
            irq_any_out     <= |pend_next;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // unmapped addresses read zero and raise pslverr
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (apb_req_in.paddr)
            cieg_pkg::IEN_A_OFFSET:  rdata[7:0]  = ien_a_reg;
            cieg_pkg::IEN_B_OFFSET:  rdata[7:0]  = ien_b_reg;
            cieg_pkg::FLAG_OFFSET:   rdata[11:0] = flag;
            cieg_pkg::PEND_OFFSET:   rdata[11:0] = pend_next;
            cieg_pkg::SHARED_OFFSET: rdata[7:0]  = shared_en_reg;
            default:                 rdata       = 32'h0000_0000;
        endcase
    end

    // answer registered: pready high during the access cycle after setup
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            apb_rsp_out <= '0;
        end else begin
            apb_rsp_out.pready  <= apb_req_in.psel & ~apb_req_in.penable;
            apb_rsp_out.pslverr <= apb_req_in.psel & ~apb_req_in.penable
                                 & ~addr_ok;
            apb_rsp_out.prdata  <= (apb_req_in.psel & ~apb_req_in.penable
                                    & ~apb_req_in.pwrite) ? rdata
                                                         : 32'h0000_0000;
        end
    end
endmodule : cieg_gate
`default_nettype wire

//--- logic/cieg_pkg.sv
// cieg_pkg: constants and carrier types for the cpu interrupt enable gating
// assumes: single cpu clock domain, apb register access with 32-bit data
package cieg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] IEN_A_OFFSET = 12'h000;
    localparam logic [11:0] IEN_B_OFFSET = 12'h004;
    localparam logic [11:0] FLAG_OFFSET  = 12'h008;
    localparam logic [11:0] PEND_OFFSET  = 12'h00c;
    localparam logic [11:0] SHARED_OFFSET = 12'h010;

    // ------------------------------------------------------------------
    // field positions, enable register a
    // ------------------------------------------------------------------
    localparam int A_GATE_BIT   = 7;
    localparam int A_SPARE_BIT  = 6;
    localparam int A_SLEEP_BIT  = 5;
    localparam int A_CIPHER_BIT = 4;
    localparam int A_SER1_BIT   = 3;
    localparam int A_SER0_BIT   = 2;
    localparam int A_CONV_BIT   = 1;
    localparam int A_RADIO_BIT  = 0;

    // ------------------------------------------------------------------
    // field positions, enable register b
    // ------------------------------------------------------------------
    localparam int B_SPARE_BIT  = 7;
    localparam int B_RO_BIT     = 6;
    localparam int B_PORT0_BIT  = 5;
    localparam int B_TIMER4_BIT = 4;
    localparam int B_TIMER3_BIT = 3;
    localparam int B_TIMER2_BIT = 2;
    localparam int B_TIMER1_BIT = 1;
    localparam int B_DMA_BIT    = 0;

    // ------------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0] IEN_A_RESET  = 8'h00;
    localparam logic [7:0] IEN_B_RESET  = 8'h00;
    localparam logic [7:0] SHARED_RESET = 8'h00;
    localparam int         NUM_SRC      = 12;

    // source index order of the request vector
    localparam int SRC_RADIO  = 0;
    localparam int SRC_CONV   = 1;
    localparam int SRC_SER0   = 2;
    localparam int SRC_SER1   = 3;
    localparam int SRC_CIPHER = 4;
    localparam int SRC_SLEEP  = 5;
    localparam int SRC_DMA    = 6;
    localparam int SRC_TIMER1 = 7;
    localparam int SRC_TIMER2 = 8;
    localparam int SRC_TIMER3 = 9;
    localparam int SRC_TIMER4 = 10;
    localparam int SRC_PORT0  = 11;

    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cieg_apb_req_t;

    // apb answer carrier
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cieg_apb_rsp_t;

    // apb slave state
    typedef enum logic [0:0] {
        CIEG_IDLE   = 1'b0,
        CIEG_ACCESS = 1'b1
    } cieg_apb_state_t;

endpackage : cieg_pkg

//--- logic/cieg_shared_src.sv
// cieg_shared_src: merges module flags that share one cpu request line
// assumes: module flags and masks come from the peripheral, same clock
`timescale 1ns/1ps
`default_nettype none
module cieg_shared_src #(
    parameter int N = 2
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [N-1:0] mod_flag_in,
    input  wire logic [N-1:0] mod_mask_in,
    output var  logic         cpu_set_out
);
    // ------------------------------------------------------------------
    // re-raise on clear
    // ------------------------------------------------------------------
    logic [N-1:0] live;
    logic [N-1:0] live_reg;
    logic         any_cleared;

    // live = flagged and allowed by the peripheral's own mask
    assign live = mod_flag_in & mod_mask_in;
    assign any_cleared = |(live_reg & ~live);

    // previous live set, to spot a flag being cleared
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            live_reg <= '0;
        end else begin
            live_reg <= live;
        end
    end

    // one-cycle set pulse: new live flag, or survivors after a clear
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cpu_set_out <= 1'b0;
        end else begin
            cpu_set_out <= (|(live & ~live_reg))
                         | (any_cleared & (|live));
        end
    end
endmodule : cieg_shared_src
`default_nettype wire

//--- tb/cieg_gate_assertions.sv
// cieg_gate_assertions: port-level checks bound onto cieg_gate
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module cieg_gate_assertions #(
    parameter int BUS_SRC = 2
) (
    input wire logic                    clk_in,
    input wire logic                    sys_rst_in,
    input wire cieg_pkg::cieg_apb_req_t apb_req_in,
    input wire cieg_pkg::cieg_apb_rsp_t apb_rsp_out,
    input wire logic [11:0]             src_event_in,
    input wire logic                    audio_rx_event_in,
    input wire logic [BUS_SRC-1:0]      bus_mod_flag_in,
    input wire logic [BUS_SRC-1:0]      bus_mod_mask_in,
    input wire logic [11:0]             cpu_flag_clr_in,
    input wire logic [11:0]             irq_pending_out,
    input wire logic                    irq_any_out
);
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // 3 and 11 also take shared paths, so only private sources here
    localparam logic [11:0] PRIV = 12'h7f7;
    logic              wr_done;
    logic              rd_ack;
    logic [11:0]       clr_only;
    logic [11:0]       rise;
    assign wr_done  = apb_rsp_out.pready & apb_req_in.pwrite;
    assign rd_ack   = apb_rsp_out.pready & ~apb_req_in.pwrite;
    assign clr_only = cpu_flag_clr_in & ~src_event_in & PRIV;
    assign rise     = irq_pending_out & PRIV;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_setup;
        apb_req_in.psel && !apb_req_in.penable;
    endsequence
    sequence s_answer;
        apb_rsp_out.pready ##1 !apb_rsp_out.pready;
    endsequence
    a_ready_next:
        assert property (s_setup |=> s_answer)
        else $error("pready not one cycle after setup");
    a_ready_cause:
        assert property (apb_rsp_out.pready |-> apb_req_in.penable)
        else $error("pready outside an access cycle");
    a_reset_quiet:
        assert property ($past(sys_rst_in) |-> irq_pending_out == 12'h000)
        else $error("pending set right after reset");
    a_any_or:
        assert property (irq_any_out == (|irq_pending_out))
        else $error("irq_any differs from or of pending");
    a_clear_drops:
        assert property (clr_only != 12'h000 |-> ##2
            (irq_pending_out & $past(clr_only, 2)) == 12'h000)
        else $error("pending held after its flag was cleared");
    a_pend_cause:
        assert property ((rise & ~$past(rise)) != 12'h000 |->
            ((rise & ~$past(rise) & ~$past(src_event_in, 2)) == 12'h000)
            || $past(wr_done) || $past(wr_done, 2))
        else $error("pending rose with no event or write");
    a_slverr_map:
        assert property (apb_rsp_out.pready && apb_req_in.paddr[1:0] == 2'b00
            |-> apb_rsp_out.pslverr == (apb_req_in.paddr > 12'h010))
        else $error("pslverr does not match the address map");
    a_b6_zero:
        assert property (rd_ack && apb_req_in.paddr == cieg_pkg::IEN_B_OFFSET
            |-> apb_rsp_out.prdata[6] == 1'b0)
        else $error("read-only bit of enable b reads one");
    a_err_zero:
        assert property (rd_ack && apb_rsp_out.pslverr
            |-> apb_rsp_out.prdata == 32'h0)
        else $error("refused read returned data");
endmodule : cieg_gate_assertions
`default_nettype wire

//--- tb/cieg_src_model.sv
// cieg_src_model: peripheral event sources and cpu vectoring stand-in
// assumes: same clock as cieg_gate; fire_in and vec_en_in from the bench
`timescale 1ns/1ps
`default_nettype none
module cieg_src_model (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [11:0] fire_in,
    input  wire logic        vec_en_in,
    input  wire logic [11:0] pending_in,
    output var  logic [11:0] event_out,
    output var  logic [11:0] clr_out
);
    // peripherals report each condition as a one-cycle pulse
    always_ff @(posedge clk_in) begin
        if (sys_rst_in)
            event_out <= 12'h000;
        else
            event_out <= fire_in;
    end
    // vectoring clears what is pending; held off models a slow cpu
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !vec_en_in)
            clr_out <= 12'h000;
        else
            clr_out <= pending_in;
    end
endmodule : cieg_src_model
`default_nettype wire

//--- tb/cpu_interrupt_enable_gating_test.sv
// cpu_interrupt_enable_gating_test: self-checking bench for cieg_gate
// assumes: package, design, source model and checker compiled before
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_enable_gating_test;
    localparam logic [11:0] A  = cieg_pkg::IEN_A_OFFSET;
    localparam logic [11:0] B  = cieg_pkg::IEN_B_OFFSET;
    localparam logic [11:0] FL = cieg_pkg::FLAG_OFFSET;
    localparam logic [11:0] PE = cieg_pkg::PEND_OFFSET;
    localparam logic [11:0] SH = cieg_pkg::SHARED_OFFSET;
    logic                    clk_in;
    logic                    sys_rst_in;
    cieg_pkg::cieg_apb_req_t req;
    cieg_pkg::cieg_apb_rsp_t rsp;
    logic [11:0]             fire, ev, clr, pend;
    logic                    audio, any, vec;
    logic [1:0]              bflag, bmask;
    logic [31:0]             x;
    logic [32:0]             exp_q[$];
    int                      fails, comparisons;
    cieg_gate u_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .apb_req_in(req), .apb_rsp_out(rsp),
        .src_event_in(ev), .audio_rx_event_in(audio),
        .bus_mod_flag_in(bflag), .bus_mod_mask_in(bmask),
        .cpu_flag_clr_in(clr), .irq_pending_out(pend), .irq_any_out(any)
    );
    cieg_src_model u_src (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .fire_in(fire),
        .vec_en_in(vec), .pending_in(pend), .event_out(ev), .clr_out(clr)
    );
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction : xs
    task automatic check(input string nm, input logic [32:0] s, e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    // holds the request until pready is seen at a rising edge, or 16 edges pass
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        @(posedge clk_in);
        req <= '{1'b1, 1'b0, w, a, d};
        if (!w) exp_q.push_back(e);
        @(posedge clk_in);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        req <= '0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd
    task automatic pulse(input logic [11:0] m, input logic au);
        @(posedge clk_in);
        fire  <= m;
        audio <= au;
        @(posedge clk_in);
        fire  <= 12'h000;
        audio <= 1'b0;
        tick(4);
    endtask : pulse
    task automatic vector_all();
        vec <= 1'b1;
        tick(6);
        vec <= 1'b0;
        tick(3);
    endtask : vector_all
    // read answers are matched in order against the noted values
    always @(posedge clk_in) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
            check("prdata", {rsp.pslverr, rsp.prdata}, exp_q.pop_front());
    end
    // a hang would otherwise stall the run; full run is ~340 cycles
    initial begin
        #(40 * 10000);
        fails++;
        final_report();
    end
    // main sequence
    initial begin
        x = 32'h97e5;
        fails = 0;
        comparisons = 0;
        req = '0;
        fire = 12'h000;
        audio = 1'b0;
        vec = 1'b0;
        bflag = 2'b00;
        bmask = 2'b00;
        sys_rst_in = 1'b1;
        tick(12);
        sys_rst_in <= 1'b0;
        rd(A, 32'h0);
        rd(B, 32'h0);
        wr(12'h020, 32'hff);
        apb(1'b0, 12'h020, 32'h0, 33'h1_0000_0000);
        for (int i = 0; i < 4; i++) begin
            x = xs(x);
            wr(A, x);
            rd(A, {24'h0, x[7:0]});
            wr(B, x);
            rd(B, {24'h0, x[7:0] & 8'hbf});
        end
        $display("test registers done");
        wr(A, 32'h7f);
        wr(B, 32'hbf);
        pulse(12'hfff, 1'b0);
        rd(FL, 32'hfff);
        rd(PE, 32'h0);
        check("irq_any", {32'h0, any}, 33'h0);
        check("irq_pending", {21'h0, pend}, 33'h0);
        wr(A, 32'hff);
        tick(3);
        rd(PE, 32'hfff);
        check("irq_pending", {21'h0, pend}, 33'hfff);
        check("irq_any", {32'h0, any}, 33'h1);
        for (int k = 0; k < 12; k++) begin
            wr(A, k < 6 ? 32'h80 | (1 << k) : 32'h80);
            wr(B, k < 6 ? 32'h0 : 1 << (k - 6));
            tick(3);
            rd(PE, 1 << k);
        end
        wr(A, 32'hc0);
        wr(B, 32'h0);
        tick(3);
        rd(PE, 32'h0);
        wr(A, 32'hff);
        wr(B, 32'hbf);
        vector_all();
        rd(FL, 32'h0);
        check("irq_any", {32'h0, any}, 33'h0);
        check("irq_pending", {21'h0, pend}, 33'h0);
        $display("test gating done");
        pulse(12'h000, 1'b1);
        rd(FL, 32'h0);
        wr(SH, 32'h1);
        rd(SH, 32'h1);
        pulse(12'h000, 1'b1);
        rd(FL, 32'h8);
        rd(PE, 32'h8);
        vector_all();
        bflag <= 2'b01;
        tick(4);
        rd(FL, 32'h0);
        bmask <= 2'b11;
        tick(4);
        rd(FL, 32'h800);
        bflag <= 2'b11;
        vector_all();
        bflag <= 2'b10;
        tick(4);
        rd(FL, 32'h800);
        $display("test shared done");
        final_report();
    end
endmodule : cpu_interrupt_enable_gating_test
bind cieg_gate cieg_gate_assertions #(.BUS_SRC(BUS_SRC)) u_chk (
    .clk_in, .sys_rst_in, .apb_req_in, .apb_rsp_out, .src_event_in,
    .audio_rx_event_in, .bus_mod_flag_in, .bus_mod_mask_in,
    .cpu_flag_clr_in, .irq_pending_out, .irq_any_out
);
`default_nettype wire
